// file: verilog/lwss_pkg.sv
// Constants and types for the late-write synchronous SRAM core
package lwss_pkg;
    // ------------------------------------------------------------
    // Timing, impedance and lane width
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int SLEEP_ENTRY_NS = 50;
    localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS * 1000) / CLK_PERIOD_PS;
    localparam int POWERUP_DWELL_US = 1000;
    localparam int POWERUP_DWELL_CYC = (POWERUP_DWELL_US * 1000000) / CLK_PERIOD_PS;
    localparam int IMP_DIV = 16;
    localparam int IMP_W = 6;
    localparam logic [IMP_W-1:0] IMP_DEFAULT = 6'h20;
    localparam int LANE_W = 9;

    // ------------------------------------------------------------
    // Cycle decode
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LWSS_DESEL = 2'h0,
        LWSS_READ = 2'h1,
        LWSS_WRITE = 2'h2
    } lwss_cyc_t;
endpackage : lwss_pkg

// file: verilog/lwss_imp_if.sv
// Interface between the core and its impedance updater
`timescale 1ns/1ps
`default_nettype none
interface lwss_imp_if;
    logic restart;
    logic [lwss_pkg::IMP_W-1:0] code;
    modport core (output restart, input code);
    modport upd (input restart, output code);
endinterface : lwss_imp_if
`default_nettype wire

// file: verilog/lwss_imp_upd.sv
// Continuous impedance updater paced by a clock divider
`timescale 1ns/1ps
`default_nettype none
module lwss_imp_upd (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [lwss_pkg::IMP_W-1:0] target,
    lwss_imp_if.upd imp
);
    localparam int DW = $clog2(lwss_pkg::IMP_DIV);
    logic [DW-1:0] div_reg;
    logic [lwss_pkg::IMP_W-1:0] code_reg;
    logic tick;
    logic up;
    logic dn;

    // ------------------------------------------------------------
    // Divider and stepping
    // ------------------------------------------------------------
    assign tick = (div_reg == DW'(lwss_pkg::IMP_DIV - 1));
    assign up = tick && (code_reg < target);
    assign dn = tick && (code_reg > target);
    assign imp.code = code_reg;

    // One code step per tick; only reset or a wake restart jumps it to the default; clock stopping stops it
    always_ff @(posedge mclk) begin
        if (!rst_n || imp.restart) begin
            div_reg <= '0;
            code_reg <= lwss_pkg::IMP_DEFAULT;
        end else begin
            div_reg <= tick ? '0 : div_reg + 1'b1;
            if (up) code_reg <= code_reg + 1'b1;
            else if (dn) code_reg <= code_reg - 1'b1;
        end
    end

    a_imp_step_small: assert property (@(posedge mclk) disable iff (!rst_n)
        !$past(imp.restart) |-> (code_reg - $past(code_reg) <= 1 ||
        $past(code_reg) - code_reg <= 1))
        else $error("impedance step larger than one");
    a_imp_paced: assert property (@(posedge mclk) disable iff (!rst_n)
        (code_reg != $past(code_reg)) && !$past(imp.restart) |-> $past(tick))
        else $error("impedance changed off the divided clock");
endmodule : lwss_imp_upd
`default_nettype wire

// file: verilog/lwss_core.sv
// Late-write synchronous SRAM core with forwarding, sleep and impedance control
`timescale 1ns/1ps
`default_nettype none
module lwss_core #(
    parameter int ADDR_W = 17,
    parameter int LANES = 4
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic chip_sel_n,
    input wire logic sync_write_n,
    input wire logic [LANES-1:0] byte_lane_write_n,
    input wire logic out_en_n,
    input wire logic sleep_request,
    input wire logic [lwss_pkg::IMP_W-1:0] impedance_program_pin,
    input wire logic [LANES*lwss_pkg::LANE_W-1:0] dq_in,
    output logic [LANES*lwss_pkg::LANE_W-1:0] dq_out,
    output logic [LANES-1:0] dq_oe,
    output logic [lwss_pkg::IMP_W-1:0] imp_code,
    output logic asleep
);
    localparam int DW = LANES * lwss_pkg::LANE_W;
    localparam int L = lwss_pkg::LANE_W;

    // Geometry the array and lane decode can serve
    if (ADDR_W < 1 || ADDR_W > 20 || LANES < 1 || LANES > 8) begin : g_bad_geometry
        $error("lwss_core: unsupported geometry");
    end
    // Entry takes three edges (two sync flops and the sleep flop)
    if (3 > lwss_pkg::SLEEP_ENTRY_CYC) begin : g_bad_sleep_entry
        $error("lwss_core: sleep entry slower than allowed");
    end

    // Carrier to the impedance updater, declared before the output flops read it
    lwss_imp_if imp ();

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Pins come from the host board; two flops before any logic.
    logic [ADDR_W-1:0] addr_s1, addr_s2;
    logic cs_s1, cs_s2, we_s1, we_s2, oe_s1, oe_s2, zz_s1, zz_s2;
    logic [LANES-1:0] bw_s1, bw_s2;
    logic [DW-1:0] din_s1, din_s2;
    logic [lwss_pkg::IMP_W-1:0] zq_s1, zq_s2;

    always_ff @(posedge mclk) begin
        addr_s1 <= addr;
        addr_s2 <= addr_s1;
        cs_s1 <= chip_sel_n;
        cs_s2 <= cs_s1;
        we_s1 <= sync_write_n;
        we_s2 <= we_s1;
        bw_s1 <= byte_lane_write_n;
        bw_s2 <= bw_s1;
        din_s1 <= dq_in;
        din_s2 <= din_s1;
        oe_s1 <= out_en_n;
        oe_s2 <= oe_s1;
        zz_s1 <= sleep_request;
        zz_s2 <= zz_s1;
        zq_s1 <= impedance_program_pin;
        zq_s2 <= zq_s1;
    end

    // ------------------------------------------------------------
    // Sleep control
    // ------------------------------------------------------------
    // Sync delay is two cycles, under the 50 ns entry limit.
    logic sleep_reg;
    logic wake_edge;
    assign wake_edge = sleep_reg && !zz_s2;

    always_ff @(posedge mclk) begin
        if (!rst_n) sleep_reg <= 1'b0;
        else sleep_reg <= zz_s2;
    end

    // ------------------------------------------------------------
    // Cycle decode
    // ------------------------------------------------------------
    lwss_pkg::lwss_cyc_t cyc;
    logic any_lane;
    logic do_read;
    logic do_write;
    assign cyc = (cs_s2 || sleep_reg) ? lwss_pkg::LWSS_DESEL :
                 (we_s2 ? lwss_pkg::LWSS_READ : lwss_pkg::LWSS_WRITE);
    assign any_lane = ~&bw_s2;
    assign do_read = (cyc == lwss_pkg::LWSS_READ);
    assign do_write = (cyc == lwss_pkg::LWSS_WRITE) && any_lane;

    // ------------------------------------------------------------
    // Array and late-write buffer
    // ------------------------------------------------------------
    logic pend_hit;
    logic pend_reg;
    logic [ADDR_W-1:0] pend_addr_reg;
    logic [LANES-1:0] pend_lanes_reg;
    logic buf_vld_reg;
    logic [ADDR_W-1:0] buf_addr_reg;
    logic [LANES-1:0] buf_lanes_reg;
    logic [DW-1:0] buf_data_reg;
    logic hit;
    logic [DW-1:0] rd_word;

    // Write issued this edge, data one edge later
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pend_reg <= 1'b0;
            pend_addr_reg <= '0;
            pend_lanes_reg <= '0;
        end else begin
            pend_reg <= do_write;
            pend_addr_reg <= addr_s2;
            pend_lanes_reg <= ~bw_s2;
        end
    end

    // Buffer holds the last write; it retires to the array when the next
    // write data lands, so a read right after a write still sees it.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            buf_vld_reg <= 1'b0;
            buf_addr_reg <= '0;
            buf_lanes_reg <= '0;
            buf_data_reg <= '0;
        end else if (pend_reg) begin
            buf_vld_reg <= 1'b1;
            buf_addr_reg <= pend_addr_reg;
            buf_lanes_reg <= pend_lanes_reg;
            buf_data_reg <= din_s2;
        end
    end

    // One array per lane, so each lane's writer is the only process on it
    generate
        for (genvar g = 0; g < LANES; g++) begin : g_lane
            logic [L-1:0] lane_mem [0:(1<<ADDR_W)-1];
            logic pend_fwd;
            logic buf_fwd;
            assign pend_fwd = pend_hit && pend_lanes_reg[g];
            assign buf_fwd = hit && buf_lanes_reg[g];
            always_ff @(posedge mclk) begin
                if (pend_reg && buf_vld_reg && buf_lanes_reg[g]) begin
                    lane_mem[buf_addr_reg] <= buf_data_reg[g*L +: L];
                end
            end
            // Newest wins: a read right behind a write sees the data still in
            // the sync flops, before the buffer has taken it
            assign rd_word[g*L +: L] = pend_fwd ? din_s2[g*L +: L] :
                (buf_fwd ? buf_data_reg[g*L +: L] : lane_mem[addr_s2]);
        end
    endgenerate
    assign hit = buf_vld_reg && (buf_addr_reg == addr_s2);
    assign pend_hit = pend_reg && (pend_addr_reg == addr_s2);

    // ------------------------------------------------------------
    // Output register and drive
    // ------------------------------------------------------------
    logic [DW-1:0] dout_reg;
    logic rd_vld_reg;
    logic drive;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dout_reg <= '0;
            rd_vld_reg <= 1'b0;
        end else begin
            if (do_read) dout_reg <= rd_word;
            // Deselect holds drive until this edge clears it
            if (do_read) rd_vld_reg <= 1'b1;
            else if (cyc == lwss_pkg::LWSS_DESEL) rd_vld_reg <= 1'b0;
            else rd_vld_reg <= 1'b0;
        end
    end
    // Write cuts drive in the cycle it is sampled; oe is asynchronous in
    // silicon but sampled here, a one-domain limitation.
    assign drive = rd_vld_reg && !oe_s2 && !sleep_reg && !zz_s2 &&
                   !(cyc == lwss_pkg::LWSS_WRITE);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dq_out <= '0;
            dq_oe <= '0;
            asleep <= 1'b0;
            imp_code <= lwss_pkg::IMP_DEFAULT;
        end else begin
            dq_out <= dout_reg;
            dq_oe <= {LANES{drive}};
            asleep <= sleep_reg;
            imp_code <= imp.code;
        end
    end

    // ------------------------------------------------------------
    // Impedance updater
    // ------------------------------------------------------------
    assign imp.restart = wake_edge;
    lwss_imp_upd u_imp (
        .mclk(mclk),
        .rst_n(rst_n),
        .target(zq_s2),
        .imp(imp)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_read_next_edge: assert property (@(posedge mclk) disable iff (!rst_n)
        do_read |=> dout_reg == $past(rd_word))
        else $error("read data not registered on next edge");
    a_write_cuts_drive: assert property (@(posedge mclk) disable iff (!rst_n)
        (cyc == lwss_pkg::LWSS_WRITE) |=> dq_oe == '0)
        else $error("drivers on after write sampled");
    a_desel_late_off: assert property (@(posedge mclk) disable iff (!rst_n)
        (cyc == lwss_pkg::LWSS_DESEL) && !sleep_reg ##1 1 |=> dq_oe == '0)
        else $error("drivers still on after deselect");
    a_empty_write_nop: assert property (@(posedge mclk) disable iff (!rst_n)
        (cyc == lwss_pkg::LWSS_WRITE) && !any_lane |=> !pend_reg)
        else $error("write with no lanes was issued");
    a_late_data_taken: assert property (@(posedge mclk) disable iff (!rst_n)
        pend_reg |=> buf_vld_reg && buf_data_reg == $past(din_s2))
        else $error("late write data not buffered");
    a_forward_hit: assert property (@(posedge mclk) disable iff (!rst_n)
        do_read && hit && buf_lanes_reg[0] && !(pend_hit && pend_lanes_reg[0]) |=>
        dout_reg[L-1:0] == $past(buf_data_reg[L-1:0]))
        else $error("buffered data not forwarded");
    a_forward_pend: assert property (@(posedge mclk) disable iff (!rst_n)
        do_read && pend_hit && pend_lanes_reg[0] |=>
        dout_reg[L-1:0] == $past(din_s2[L-1:0]))
        else $error("pending write data not forwarded");
    a_addr_capture: assert property (@(posedge mclk) disable iff (!rst_n)
        do_write |=> pend_reg && pend_addr_reg == $past(addr_s2))
        else $error("write address not captured");
    a_wake_default: assert property (@(posedge mclk) disable iff (!rst_n)
        wake_edge |=> imp.code == lwss_pkg::IMP_DEFAULT)
        else $error("impedance not back at default after wake");
    a_asleep_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        sleep_reg |=> asleep)
        else $error("sleep state not reported");
    a_sleep_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
        sleep_reg |-> !do_read && !do_write ##1 dq_oe == '0)
        else $error("activity while asleep");
    a_sleep_entry: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(zz_s2) |=> sleep_reg)
        else $error("sleep entry too slow");
    a_oe_gates: assert property (@(posedge mclk) disable iff (!rst_n)
        oe_s2 |=> dq_oe == '0)
        else $error("drivers on with output enable high");
endmodule : lwss_core
`default_nettype wire

// file: tb/lwss_host_model.sv
// Host-side bus model that drives the core as a cache controller would
`timescale 1ns/1ps
`default_nettype none
module lwss_host_model #(
    parameter int ADDR_W = 17,
    parameter int LANES = 4
) (
    input wire logic mclk,
    output logic [ADDR_W-1:0] addr,
    output logic chip_sel_n,
    output logic sync_write_n,
    output logic [LANES-1:0] byte_lane_write_n,
    output logic out_en_n,
    output logic sleep_request,
    output logic [lwss_pkg::IMP_W-1:0] impedance_program_pin,
    output logic [LANES*lwss_pkg::LANE_W-1:0] dq_in
);
    logic last_rd;
    // --------------------------------------------------------
    // Bus tasks; every change except oe_set lands on the falling edge
    // --------------------------------------------------------
    initial begin
        addr = '0;
        chip_sel_n = 1'b1;
        sync_write_n = 1'b1;
        byte_lane_write_n = '1;
        out_en_n = 1'b0;
        sleep_request = 1'b0;
        impedance_program_pin = 6'h23;
        dq_in = '0;
        last_rd = 1'b0;
    end
    // Address toggles while deselected so a stale value never looks valid
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge mclk);
            dq_in = ~dq_in;
            addr = ~addr;
            chip_sel_n = 1'b1; // Deselect cycle
            last_rd = 1'b0;
        end
    endtask : idle
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [LANES-1:0] lanes_n,
                      input logic [LANES*lwss_pkg::LANE_W-1:0] d);
        if (last_rd) idle(1); // Dead cycle before a write
        @(negedge mclk);
        addr = a;
        chip_sel_n = 1'b0;
        sync_write_n = 1'b0; // Select low, write low
        byte_lane_write_n = lanes_n;
        @(negedge mclk);
        chip_sel_n = 1'b1;
        addr = ~a;
        dq_in = d; // Data follows its address by one edge
        last_rd = 1'b0;
    endtask : wr
    // Write, then its read on the very next edge; the data rides in the read cycle
    task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [LANES-1:0] lanes_n,
                         input logic [LANES*lwss_pkg::LANE_W-1:0] d,
                         input logic [ADDR_W-1:0] ra);
        if (last_rd) idle(1); // Dead cycle before a write
        @(negedge mclk);
        addr = a;
        chip_sel_n = 1'b0;
        sync_write_n = 1'b0; // Select low, write low
        byte_lane_write_n = lanes_n;
        @(negedge mclk);
        addr = ra;
        sync_write_n = 1'b1; // No idle cycle after a write
        byte_lane_write_n = '0;
        dq_in = d; // Data follows its address by one edge
        last_rd = 1'b1;
    endtask : wr_rd
    // Output enable is a level; no bus edge is needed to change it
    task automatic oe_set(input logic v);
        out_en_n = v;
    endtask : oe_set
    // Lane enables held active on reads: the core must ignore them
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(negedge mclk);
        dq_in = ~dq_in;
        addr = a;
        chip_sel_n = 1'b0;
        sync_write_n = 1'b1; // Reads may follow writes at once
        byte_lane_write_n = '0;
        last_rd = 1'b1;
    endtask : rd
    task automatic sleep_set(input logic v);
        idle(3); // Quiet bus around sleep edges
        @(negedge mclk);
        sleep_request = v;
    endtask : sleep_set
endmodule : lwss_host_model
`default_nettype wire

// file: tb/lwss_core_bench.sv
// Self-checking bench for the late-write synchronous SRAM core
`timescale 1ns/1ps
`default_nettype none
module lwss_core_bench;
    localparam int DW = 4 * lwss_pkg::LANE_W;
    localparam logic [16:0] A1 = 17'h000a5;
    localparam logic [16:0] A2 = 17'h1035a;
    localparam logic [35:0] D1 = 36'h123456789;
    localparam logic [35:0] D2 = 36'hfedcba987;
    localparam logic [35:0] D3 = 36'h5a5a5a5a5;
    logic mclk;
    logic rst_n;
    logic [16:0] addr;
    logic chip_sel_n, sync_write_n, out_en_n, sleep_request, asleep;
    logic [3:0] byte_lane_write_n, dq_oe;
    logic [5:0] impedance_program_pin, imp_code;
    logic [DW-1:0] dq_in, dq_out, exp_a1;
    int errors, compares, cycles;
    bit seen;
    lwss_host_model i_lwss_host_model (.mclk(mclk), .addr(addr), .chip_sel_n(chip_sel_n),
        .sync_write_n(sync_write_n), .byte_lane_write_n(byte_lane_write_n),
        .out_en_n(out_en_n), .sleep_request(sleep_request),
        .impedance_program_pin(impedance_program_pin), .dq_in(dq_in));
    lwss_core i_lwss_core (.mclk(mclk), .rst_n(rst_n), .addr(addr), .chip_sel_n(chip_sel_n),
        .sync_write_n(sync_write_n), .byte_lane_write_n(byte_lane_write_n),
        .out_en_n(out_en_n), .sleep_request(sleep_request),
        .impedance_program_pin(impedance_program_pin), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe(dq_oe), .imp_code(imp_code), .asleep(asleep));
    // --------------------------------------------------------
    // Clock, reset and hang guard
    // --------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic check(input string name, input logic [63:0] seen_v, input logic [63:0] exp);
        compares++;
        if (seen_v !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen_v);
        end
    endtask : check
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    // Deselect, then look in the one cycle where the word must be driven
    task automatic await_read(input logic [DW-1:0] exp);
        i_lwss_host_model.idle(1);
        repeat (3) @(negedge mclk);
        check("dq_out", dq_out, exp);
        check("dq_oe", dq_oe, 4'hf);
    endtask : await_read
    task automatic read_check(input logic [16:0] a, input logic [DW-1:0] exp);
        i_lwss_host_model.rd(a);
        await_read(exp);
    endtask : read_check
    // --------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------
    task automatic t_forward();
        exp_a1 = D1;
        i_lwss_host_model.wr_rd(A1, 4'h0, D1, A1);
        await_read(exp_a1);
        i_lwss_host_model.wr(A1, 4'hd, D2);
        exp_a1 = (exp_a1 & ~36'h00003fe00) | (D2 & 36'h00003fe00);
        read_check(A1, exp_a1);
    endtask : t_forward
    // A2 retires to the array while A1 sits in the buffer
    task automatic t_array();
        i_lwss_host_model.wr(A2, 4'h0, D3);
        i_lwss_host_model.wr(A1, 4'he, D3);
        exp_a1 = (exp_a1 & ~36'h0000001ff) | (D3 & 36'h0000001ff);
        read_check(A2, D3);
        read_check(A1, exp_a1);
        i_lwss_host_model.wr(A1, 4'hf, D2);
        read_check(A1, exp_a1);
        i_lwss_host_model.idle(6);
        check("dq_oe", dq_oe, 4'h0);
    endtask : t_array
    task automatic t_out_en();
        for (int i = 0; i < 10; i++) begin
            i_lwss_host_model.rd(A1);
            if (i == 5) check("dq_oe", dq_oe, 4'hf);
            if (i == 5) i_lwss_host_model.oe_set(1'b1);
        end
        check("dq_oe", dq_oe, 4'h0);
        i_lwss_host_model.oe_set(1'b0);
    endtask : t_out_en
    // Bus stays quiet around entry and recovery; data is not trusted meanwhile
    task automatic t_sleep();
        check("imp_code", imp_code, 6'h23);
        i_lwss_host_model.sleep_set(1'b1);
        repeat (16) @(negedge mclk);
        check("asleep", asleep, 1'b1);
        check("dq_oe", dq_oe, 4'h0);
        i_lwss_host_model.wr(A1, 4'h0, D3);
        i_lwss_host_model.sleep_set(1'b0);
        seen = 1'b0;
        repeat (60) begin
            @(negedge mclk);
            if (imp_code === lwss_pkg::IMP_DEFAULT) seen = 1'b1;
        end
        check("imp_restart", seen, 1'b1);
        check("asleep", asleep, 1'b0);
        read_check(A1, exp_a1);
    endtask : t_sleep
    initial begin
        errors = 0;
        compares = 0;
        cycles = 0;
        rst_n = 1'b0;
        repeat (8) @(negedge mclk);
        rst_n = 1'b1;
        i_lwss_host_model.idle(4); // Short dwell: the model has no supply ramp
        t_forward();
        t_array();
        t_out_en();
        t_sleep();
        print_verdict();
    end
endmodule : lwss_core_bench
`default_nettype wire
